// >>> rtl/dmz_ctrl_end.sv
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module dmz_ctrl_end #(
  parameter int COL_W      = 6,
  parameter int WR_TIME_NS = dmz_pkg::WRITE_RECOVERY_TIME_NS,
  parameter int SLOW_NS    = dmz_pkg::SLOW_EXIT_NS,
  parameter int FAST_NS    = dmz_pkg::FAST_EXIT_NS
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // memory link
  dmz_link_if.ctl          link
);

  localparam int         WR_MIN   = dmz_pkg::ns_to_cyc(WR_TIME_NS);
  localparam logic [2:0] WR_CODE  = dmz_pkg::wr_code(WR_MIN);
  localparam logic [7:0] WR_CYC   = 8'(dmz_pkg::wr_cycles(WR_CODE));
  localparam logic [7:0] SLOW_CYC = 8'(dmz_pkg::ns_to_cyc(SLOW_NS));
  localparam logic [7:0] FAST_CYC = 8'(dmz_pkg::ns_to_cyc(FAST_NS));

  if (WR_MIN > 12 || dmz_pkg::ns_to_cyc(SLOW_NS) > 255 || dmz_pkg::ns_to_cyc(FAST_NS) > 255
      || COL_W < 3 || COL_W > 16) begin : g_bad
    $error("controller parameters out of range");
  end

  typedef enum logic [2:0] {CT_IDLE, CT_RD_HOLD, CT_RD_WAIT, CT_RD_BEAT,
                            CT_WR_WAIT, CT_WR_BEAT, CT_GAP, CT_PD} dmz_ctl_st_t;

  dmz_ctl_st_t st_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [16:0] addr_q;
  logic [63:0] wbuf_q;
  logic [63:0] rbuf_q;
  logic [7:0]  cnt_q;
  logic [2:0]  beat_q;
  logic [9:0]  dll_cnt_q;
  logic [3:0]  cl_q;
  logic [1:0]  bl_q;
  logic        ppd_q;
  logic        chop_q;
  logic        wr_fire;
  logic        go;
  logic [2:0]  op;
  logic        rd_issue;
  logic        mrs_issue;
  logic [2:0]  slot;
  logic        take;
  logic        dfire;
  logic        cfire;

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  // ----------
  // axi4-lite slave
  // ----------
  always_comb begin
    wr_fire   = aw_have_q && w_have_q;
    go        = wr_fire && awaddr_q == dmz_pkg::OFS_CMD && wstrb_q[0];
    op        = wdata_q[2:0];
    mrs_issue = (st_q == CT_IDLE) && go && op == dmz_pkg::OP_MRS;
    rd_issue  = (st_q == CT_RD_HOLD) && dll_cnt_q == 10'h000; // R13
    slot      = (st_q == CT_RD_BEAT || st_q == CT_WR_BEAT) ? 3'(beat_q + 3'h1) : 3'h0;
    take      = !(chop_q && slot[2]);
    dfire     = (st_q == CT_WR_WAIT && cnt_q == 8'h01) || (st_q == CT_WR_BEAT && beat_q != 3'h7);
    cfire     = (st_q == CT_RD_WAIT && cnt_q == 8'h01) || (st_q == CT_RD_BEAT && beat_q != 3'h7);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= dmz_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q <= dmz_pkg::OFS_WHI && awaddr_q[1:0] == 2'h0)
                        ? dmz_pkg::RESP_OKAY : dmz_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= dmz_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= dmz_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        dmz_pkg::OFS_CMD:  s_axi_rdata <= 32'h0000_0000;
        dmz_pkg::OFS_ADDR: s_axi_rdata <= 32'(addr_q);
        dmz_pkg::OFS_WLO:  s_axi_rdata <= wbuf_q[31:0];
        dmz_pkg::OFS_WHI:  s_axi_rdata <= wbuf_q[63:32];
        dmz_pkg::OFS_RLO:  s_axi_rdata <= rbuf_q[31:0];
        dmz_pkg::OFS_RHI:  s_axi_rdata <= rbuf_q[63:32];
        dmz_pkg::OFS_STAT: s_axi_rdata <= {29'h0000_0000, st_q == CT_PD, dll_cnt_q == 10'h000, st_q != CT_IDLE};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= dmz_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= 17'h0_0000;
      wbuf_q <= 64'h0000_0000_0000_0000;
    end else if (wr_fire) begin
      if (awaddr_q == dmz_pkg::OFS_ADDR) addr_q <= 17'(merge(32'(addr_q), wdata_q, wstrb_q));
      if (awaddr_q == dmz_pkg::OFS_WLO) wbuf_q[31:0] <= merge(wbuf_q[31:0], wdata_q, wstrb_q);
      if (awaddr_q == dmz_pkg::OFS_WHI) wbuf_q[63:32] <= merge(wbuf_q[63:32], wdata_q, wstrb_q);
    end
  end

  // ----------
  // dll lock wait
  // ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dll_cnt_q <= 10'h000;
    end else if (mrs_issue && addr_q[dmz_pkg::DLL_RST_BIT]) begin
      dll_cnt_q <= 10'(dmz_pkg::DLL_LOCK_WAIT_CYC); // R11 R13
    end else if (dll_cnt_q != 10'h000) begin
      dll_cnt_q <= dll_cnt_q - 10'h001;
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= CT_IDLE;
      cnt_q        <= 8'h00;
      beat_q       <= 3'h0;
      cl_q         <= 4'h0;
      bl_q         <= dmz_pkg::BL_EIGHT;
      ppd_q        <= 1'b0;
      chop_q       <= 1'b0;
      link.cke     <= 1'b1;
      link.cmd     <= dmz_pkg::LK_NOP;
      link.addr    <= 16'h0000;
      link.len_sel <= 1'b0;
    end else begin
      link.cmd <= dmz_pkg::LK_NOP;
      unique case (st_q)
        CT_IDLE: begin
          link.len_sel <= addr_q[dmz_pkg::ADDR_LEN_BIT];
          chop_q       <= dmz_pkg::chop_sel(bl_q, addr_q[dmz_pkg::ADDR_LEN_BIT]); // R22
          if (mrs_issue) begin
            link.cmd  <= dmz_pkg::LK_MRS;
            link.addr <= {addr_q[15:12], WR_CODE, addr_q[8:0]}; // R15
            cl_q      <= dmz_pkg::cl_cycles(addr_q[dmz_pkg::CL_LSB +: 3]);
            bl_q      <= addr_q[dmz_pkg::BL_LSB +: 2];
            ppd_q     <= addr_q[dmz_pkg::PPD_BIT];
            cnt_q     <= 8'(dmz_pkg::MOD_WAIT_CYC);
            st_q      <= CT_GAP;
          end else if (go && op == dmz_pkg::OP_WR) begin
            link.cmd  <= dmz_pkg::LK_WR;
            link.addr <= addr_q[15:0];
            cnt_q     <= 8'(dmz_pkg::WRITE_LAT_CYC);
            st_q      <= CT_WR_WAIT;
          end else if (go && op == dmz_pkg::OP_RD && cl_q != 4'h0) begin
            st_q <= CT_RD_HOLD;
          end else if (go && op == dmz_pkg::OP_PD_ENTER) begin
            link.cke <= 1'b0;
            st_q     <= CT_PD;
          end
        end
        CT_RD_HOLD: begin
          if (rd_issue) begin
            link.cmd  <= dmz_pkg::LK_RD; // R13
            link.addr <= addr_q[15:0];
            cnt_q     <= 8'(cl_q + 4'h2); // sample an edge after the device drives
            st_q      <= CT_RD_WAIT;
          end
        end
        CT_RD_WAIT, CT_WR_WAIT: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q   <= (st_q == CT_RD_WAIT) ? CT_RD_BEAT : CT_WR_BEAT;
            beat_q <= 3'h0;
          end
        end
        CT_RD_BEAT, CT_WR_BEAT: begin
          if (beat_q != 3'h7) begin
            beat_q <= beat_q + 3'h1;
          end else if (st_q == CT_WR_BEAT) begin
            cnt_q <= WR_CYC;
            st_q  <= CT_GAP;
          end else begin
            st_q <= CT_IDLE;
          end
        end
        CT_GAP: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q <= 8'h01) st_q <= CT_IDLE;
        end
        CT_PD: begin
          if (go && op == dmz_pkg::OP_PD_EXIT) begin
            link.cke <= 1'b1;
            cnt_q    <= ppd_q ? FAST_CYC : SLOW_CYC; // R17 R18
            st_q     <= CT_GAP;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // write drive and read capture
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.ctl_dq     <= '0;
      link.ctl_dq_oe  <= 1'b0;
      link.ctl_dqs    <= 1'b0;
      link.ctl_dqs_oe <= 1'b0;
    end else if (dfire) begin
      link.ctl_dq     <= wbuf_q[{slot, 3'h0} +: 8];
      link.ctl_dq_oe  <= take;
      link.ctl_dqs    <= ~slot[0];
      link.ctl_dqs_oe <= take;
    end else begin
      link.ctl_dq_oe  <= 1'b0;
      link.ctl_dqs    <= 1'b0;
      link.ctl_dqs_oe <= 1'b0;
    end
  end

  // chop slots four to seven read back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn || rd_issue) begin
      rbuf_q <= 64'h0000_0000_0000_0000;
    end else if (cfire && take) begin
      rbuf_q[{slot, 3'h0} +: 8] <= link.dq;
    end
  end

endmodule

// >>> rtl/dmz_dram_end.sv
`timescale 1ns/100ps
// What this block and the controller do
// [R1] mode bit three picks burst type
// [R2] order from length, type, low column bits
// [R3] sequential read wraps within nibble, then other
// [R4] interleaved read beat is start xor k
// [R5] chop read drives four slots, then floats
// [R6] chop read stays in nibble of bit two
// [R7] chop write: natural order within nibble
// [R8] eight-beat write: natural order always
// [R9] chop bursts start like eight-beat bursts
// [R10] only chop-four and eight-beat forms
// [R11] mode bit eight starts dll reset
// [R12] dll reset bit clears itself
// [R13] controller waits 512 cycles before read
// [R14] write recovery from bits eleven to nine
// [R15] controller rounds recovery time up
// [R16] dll option only in precharge powerdown
// [R17] bit twelve clear: dll stops, slow exit
// [R18] bit twelve set: dll runs, fast exit
// [R19] read latency from bits six to four
// [R20] first read beat at edge n plus m
// [R21] whole-clock read latencies only
// [R22] length bits; otf line twelve picks length (here the separate len_sel line)
// [R23] burst wraps inside aligned column block
// [R24] decode type; reserved codes treated reserved, except length code 11, which runs as eight beats
module dmz_dram_end #(
  parameter int COL_W = 6
) (
  // clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // memory link
  dmz_link_if.dev     link,
  // device state
  output logic [15:0] base_mode_register,
  output logic        dll_locked,
  output logic        dll_running,
  output logic        in_powerdown
);

  generate
    if (COL_W < 3 || COL_W > 16) begin : g_bad_col
      $error("column width out of range");
    end
  endgenerate

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [2:0] {DV_IDLE, DV_RD_WAIT, DV_RD_BEAT, DV_WR_WAIT, DV_WR_BEAT} dmz_dev_st_t;

  dmz_dev_st_t              st_q;
  logic [dmz_pkg::DQ_W-1:0] mem_q [2**COL_W];
  logic [3:0]               cnt_q;
  logic [2:0]               beat_q;
  logic [COL_W-1:0]         start_q;
  logic                     chop_q;
  logic                     ilv_q;
  logic [9:0]               dll_cnt_q;
  logic [3:0]               lat;
  logic                     idle;
  logic                     is_wr;
  logic                     rd_fire;
  logic                     wr_fire;
  logic                     take;
  logic                     accept;
  logic [2:0]               slot;
  logic [COL_W-1:0]         col;

  // ----------
  // decode
  // ----------
  always_comb begin
    lat     = dmz_pkg::cl_cycles(base_mode_register[dmz_pkg::CL_LSB +: 3]); // R19
    idle    = (st_q == DV_IDLE);
    accept  = idle && link.cke;
    is_wr   = (st_q == DV_WR_WAIT) || (st_q == DV_WR_BEAT);
    slot    = (st_q == DV_RD_BEAT || st_q == DV_WR_BEAT) ? 3'(beat_q + 3'h1) : 3'h0;
    rd_fire = (st_q == DV_RD_WAIT && cnt_q == 4'h1) || (st_q == DV_RD_BEAT && beat_q != 3'h7);
    wr_fire = (st_q == DV_WR_WAIT && cnt_q == 4'h1) || (st_q == DV_WR_BEAT && beat_q != 3'h7);
    take    = !(chop_q && slot[2]); // R5 R7
    col     = {start_q[COL_W-1:3], dmz_pkg::beat_col(start_q[2:0], slot, ilv_q, chop_q, is_wr)}; // R2 R23
  end

  // ----------
  // mode register
  // ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_mode_register <= dmz_pkg::MODE_RST;
    end else if (accept && link.cmd == dmz_pkg::LK_MRS) begin
      // reserved positions are forced to zero
      base_mode_register <= link.addr & dmz_pkg::MODE_MASK; // R11 R14 R24
    end else if (base_mode_register[dmz_pkg::DLL_RST_BIT]) begin
      base_mode_register[dmz_pkg::DLL_RST_BIT] <= 1'b0; // R12
    end
  end

  // ----------
  // dll
  // ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dll_cnt_q  <= 10'h000;
      dll_locked <= 1'b0;
    end else if (base_mode_register[dmz_pkg::DLL_RST_BIT]) begin
      dll_cnt_q  <= 10'(dmz_pkg::DLL_LOCK_WAIT_CYC); // R11
      dll_locked <= 1'b0;
    end else if (dll_cnt_q != 10'h000) begin
      dll_cnt_q  <= dll_cnt_q - 10'h001;
      dll_locked <= (dll_cnt_q == 10'h001);
    end
  end

  // powerdown only counts as precharge powerdown when no burst runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_powerdown <= 1'b0;
      dll_running  <= 1'b0;
    end else begin
      in_powerdown <= idle && !link.cke; // R16
      dll_running  <= !(idle && !link.cke) || base_mode_register[dmz_pkg::PPD_BIT]; // R17 R18
    end
  end

  // ----------------------------------------
  // burst sequencer
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q    <= DV_IDLE;
      cnt_q   <= 4'h0;
      beat_q  <= 3'h0;
      start_q <= '0;
      chop_q  <= 1'b0;
      ilv_q   <= 1'b0;
    end else begin
      unique case (st_q)
        DV_IDLE: begin
          start_q <= link.addr[COL_W-1:0];
          // reserved length code 11 runs as eight beats
          chop_q  <= dmz_pkg::chop_sel(base_mode_register[dmz_pkg::BL_LSB +: 2], link.len_sel); // R10 R22
          ilv_q   <= base_mode_register[dmz_pkg::BT_BIT]; // R1 R24
          if (accept && link.cmd == dmz_pkg::LK_RD && lat != 4'h0) begin // R21 R24
            st_q  <= DV_RD_WAIT;
            cnt_q <= lat; // R20 R9
          end else if (accept && link.cmd == dmz_pkg::LK_WR) begin
            st_q  <= DV_WR_WAIT;
            cnt_q <= 4'(dmz_pkg::WRITE_LAT_CYC); // R9
          end
        end
        DV_RD_WAIT, DV_WR_WAIT: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            st_q   <= (st_q == DV_RD_WAIT) ? DV_RD_BEAT : DV_WR_BEAT;
            beat_q <= 3'h0;
          end
        end
        DV_RD_BEAT, DV_WR_BEAT: begin
          // all eight slots elapse even for chop bursts
          if (beat_q == 3'h7) begin
            st_q <= DV_IDLE; // R9
          end else begin
            beat_q <= beat_q + 3'h1;
          end
        end
        default: begin
          st_q <= DV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data drivers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.dev_dq     <= '0;
      link.dev_dq_oe  <= 1'b0;
      link.dev_dqs    <= 1'b0;
      link.dev_dqs_oe <= 1'b0;
    end else if (rd_fire) begin
      link.dev_dq     <= mem_q[col]; // R3 R4 R6
      link.dev_dq_oe  <= take; // R5
      link.dev_dqs    <= ~slot[0];
      link.dev_dqs_oe <= take; // R5
    end else begin
      link.dev_dq_oe  <= 1'b0;
      link.dev_dqs    <= 1'b0;
      link.dev_dqs_oe <= 1'b0;
    end
  end

  // ----------------------------------------
  // write capture
  // ----------------------------------------
  // array has no reset; contents are undefined until written
  always_ff @(posedge aclk) begin
    if (wr_fire && take) begin
      mem_q[col] <= link.dq; // R7 R8
    end
  end

endmodule

// >>> rtl/dmz_link_if.sv
`timescale 1ns/100ps
interface dmz_link_if;
  logic                     cke;
  dmz_pkg::dmz_cmd_t        cmd;
  logic [15:0]              addr;
  logic                     len_sel;
  logic [dmz_pkg::DQ_W-1:0] ctl_dq;
  logic                     ctl_dq_oe;
  logic                     ctl_dqs;
  logic                     ctl_dqs_oe;
  logic [dmz_pkg::DQ_W-1:0] dev_dq;
  logic                     dev_dq_oe;
  logic                     dev_dqs;
  logic                     dev_dqs_oe;
  logic [dmz_pkg::DQ_W-1:0] dq;
  logic                     dqs;

  // undriven wire reads as zero
  assign dq  = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);
  assign dqs = dev_dqs_oe ? dev_dqs : (ctl_dqs_oe && ctl_dqs);

  modport dev (input cke, cmd, addr, len_sel, dq, dqs,
               output dev_dq, dev_dq_oe, dev_dqs, dev_dqs_oe);
  modport ctl (output cke, cmd, addr, len_sel, ctl_dq, ctl_dq_oe, ctl_dqs, ctl_dqs_oe,
               input dq, dqs);
endinterface

// >>> rtl/dmz_pkg.sv
package dmz_pkg;
  // ----------------------------------------
  // clock and link widths
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int DQ_W    = 8;

  // ----------------------------------------
  // base mode register layout
  // ----------------------------------------
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [15:0] MODE_MASK = 16'h1f7b;
  localparam int BL_LSB      = 0;
  localparam int BT_BIT      = 3;
  localparam int CL_LSB      = 4;
  localparam int DLL_RST_BIT = 8;
  localparam int WR_LSB      = 9;
  localparam int PPD_BIT     = 12;
  localparam logic [1:0] BL_EIGHT = 2'h0;
  localparam logic [1:0] BL_OTF   = 2'h1;
  localparam logic [1:0] BL_CHOP  = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int DLL_LOCK_WAIT_CYC      = 512;
  localparam int WRITE_LAT_CYC          = 5;
  localparam int MOD_WAIT_CYC           = 12;
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int SLOW_EXIT_NS           = 96;
  localparam int FAST_EXIT_NS           = 24;

  // ----------------------------------------
  // controller registers
  // ----------------------------------------
  localparam logic [7:0] OFS_CMD  = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WLO  = 8'h08;
  localparam logic [7:0] OFS_WHI  = 8'h0c;
  localparam logic [7:0] OFS_RLO  = 8'h10;
  localparam logic [7:0] OFS_RHI  = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam int ADDR_LEN_BIT = 16;
  localparam logic [2:0] OP_MRS      = 3'h1;
  localparam logic [2:0] OP_WR       = 3'h2;
  localparam logic [2:0] OP_RD       = 3'h3;
  localparam logic [2:0] OP_PD_ENTER = 3'h4;
  localparam logic [2:0] OP_PD_EXIT  = 3'h5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {LK_NOP, LK_MRS, LK_RD, LK_WR} dmz_cmd_t;

  // ----------------------------------------
  // decoding
  // ----------------------------------------
  function automatic int ns_to_cyc(int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic logic [3:0] cl_cycles(logic [2:0] code);
    case (code)
      3'h1: return 4'h5;
      3'h2: return 4'h6;
      3'h3: return 4'h7;
      3'h4: return 4'h8;
      3'h5: return 4'h9;
      3'h6: return 4'ha;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [3:0] wr_cycles(logic [2:0] code);
    case (code)
      3'h1: return 4'h5;
      3'h2: return 4'h6;
      3'h3: return 4'h7;
      3'h4: return 4'h8;
      3'h5: return 4'ha;
      3'h6: return 4'hc;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [2:0] wr_code(int cyc);
    if (cyc <= 5) return 3'h1;
    if (cyc <= 6) return 3'h2;
    if (cyc <= 7) return 3'h3;
    if (cyc <= 8) return 3'h4;
    if (cyc <= 10) return 3'h5;
    return 3'h6;
  endfunction

  function automatic logic chop_sel(logic [1:0] bl, logic len);
    return (bl == BL_CHOP) || (bl == BL_OTF && !len);
  endfunction

  function automatic logic [2:0] beat_col(logic [2:0] s, logic [2:0] k, logic ilv, logic chop, logic wr);
    if (wr) return chop ? {s[2], k[1:0]} : k;
    if (ilv) return s ^ k;
    return {s[2] ^ k[2], 2'(s[1:0] + k[1:0])};
  endfunction
endpackage

// >>> testbench/dmz_link_properties.sv
`timescale 1ns/100ps
module dmz_link_props (
  // clock and reset
  input logic              aclk,
  input logic              aresetn,
  // link
  input logic              cke,
  input dmz_pkg::dmz_cmd_t cmd,
  input logic [15:0]       addr,
  input logic              ctl_dq_oe,
  input logic              dev_dq_oe,
  input logic              dev_dqs,
  input logic              dev_dqs_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------
  // properties
  // ----------
  property p_dqs; dev_dqs_oe == dev_dq_oe; endproperty
  a_dqs: assert property (p_dqs) else $error("strobe and data enables differ");
  property p_rd_quiet; cmd == dmz_pkg::LK_RD |=> !dev_dq_oe [*5]; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data too early");
  property p_rd_start; cmd == dmz_pkg::LK_RD |-> ##[6:11] dev_dq_oe; endproperty
  a_rd_start: assert property (p_rd_start) else $error("read data late");
  property p_len; $rose(dev_dq_oe) |-> dev_dq_oe [*4] ##1 (!dev_dq_oe or dev_dq_oe [*4] ##1 !dev_dq_oe); endproperty
  a_len: assert property (p_len) else $error("burst not four or eight slots");
  property p_phase; $rose(dev_dq_oe) |-> dev_dqs ##1 !dev_dqs ##1 dev_dqs; endproperty
  a_phase: assert property (p_phase) else $error("strobe phase wrong");
  property p_wr_code; cmd == dmz_pkg::LK_MRS |-> addr[11:9] == 3'h1; endproperty
  a_wr_code: assert property (p_wr_code) else $error("write recovery code wrong");
  property p_pd; !cke |-> cmd == dmz_pkg::LK_NOP; endproperty
  a_pd: assert property (p_pd) else $error("command during powerdown");
  property p_wr; cmd == dmz_pkg::LK_WR |-> ##5 ctl_dq_oe [*4]; endproperty
  a_wr: assert property (p_wr) else $error("write beats misplaced");
  c_rd: cover property (cmd == dmz_pkg::LK_RD);
  c_wr: cover property (cmd == dmz_pkg::LK_WR);
  c_pd: cover property (!cke);
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdv, lo;
  logic [15:0] bmr;
  logic        dll_locked, dll_running, in_pd;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cyc = 0;
  always #20 aclk = ~aclk;
  dmz_link_if i_dmz_link_if ();
  dmz_dram_end i_dmz_dram_end (.aclk, .aresetn, .link(i_dmz_link_if), .base_mode_register(bmr),
    .dll_locked, .dll_running, .in_powerdown(in_pd));
  dmz_ctrl_end i_dmz_ctrl_end (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link(i_dmz_link_if));
  dmz_link_props u_chk (.aclk, .aresetn, .cke(i_dmz_link_if.cke), .cmd(i_dmz_link_if.cmd),
    .addr(i_dmz_link_if.addr), .ctl_dq_oe(i_dmz_link_if.ctl_dq_oe),
    .dev_dq_oe(i_dmz_link_if.dev_dq_oe), .dev_dqs(i_dmz_link_if.dev_dqs),
    .dev_dqs_oe(i_dmz_link_if.dev_dqs_oe));
  // ----------
  // tasks
  // ----------
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // w: poll status until idle; powerdown stays busy
  task automatic go(input logic [16:0] ad, input logic [2:0] op, input logic w);
    wr(dmz_pkg::OFS_ADDR, {15'h0000, ad});
    wr(dmz_pkg::OFS_CMD, {29'h0000_0000, op});
    repeat (6) @(posedge aclk);
    if (w) do rd(dmz_pkg::OFS_STAT); while (rdv[0] !== 1'h0);
  endtask
  task automatic rdb(input logic [16:0] ad, input logic [63:0] e);
    go(ad, dmz_pkg::OP_RD, 1'h1);
    rd(dmz_pkg::OFS_RLO);
    lo = rdv;
    rd(dmz_pkg::OFS_RHI);
    chk("beats", e, {rdv, lo});
  endtask
  task automatic t_mode;
    go(17'h0_3f95, dmz_pkg::OP_MRS, 1'h1);
    chk("mode", 64'h1211, 64'(bmr));
    repeat (400) @(posedge aclk);
    chk("dll_early", 64'h0, 64'(dll_locked));
    do rd(dmz_pkg::OFS_STAT); while (rdv[1] !== 1'h1);
    repeat (2) @(posedge aclk);
    chk("dll_lock", 64'h1, 64'(dll_locked));
  endtask
  task automatic t_data;
    wr(dmz_pkg::OFS_WLO, 32'ha3a2_a1a0);
    wr(dmz_pkg::OFS_WHI, 32'ha7a6_a5a4);
    go(17'h1_0005, dmz_pkg::OP_WR, 1'h1);
    rdb(17'h1_0003, 64'ha6a5_a4a7_a2a1_a0a3);
    rdb(17'h0_0005, 64'h0000_0000_a4a7_a6a5);
    wr(dmz_pkg::OFS_WLO, 32'hb3b2_b1b0);
    go(17'h0_0006, dmz_pkg::OP_WR, 1'h1);
    go(17'h0_1069, dmz_pkg::OP_MRS, 1'h1);
    chk("mode", 64'h1269, 64'(bmr));
    rdb(17'h1_0005, 64'ha2a3_a0a1_b2b3_b0b1);
    rdb(17'h0_0003, 64'h0000_0000_a0a1_a2a3);
  endtask
  task automatic t_pd(input logic [15:0] m, input logic r);
    go({1'h0, m}, dmz_pkg::OP_MRS, 1'h1);
    go(17'h0_0000, dmz_pkg::OP_PD_ENTER, 1'h0);
    chk("pd", 64'h1, 64'(in_pd));
    chk("dll_run", 64'(r), 64'(dll_running));
    go(17'h0_0000, dmz_pkg::OP_PD_EXIT, 1'h1);
    chk("dll_back", 64'h1, 64'(dll_running));
  endtask
  // ----------
  // sequence
  // ----------
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize;
    end
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    t_mode;
    t_data;
    t_pd(16'h1069, 1'h1);
    t_pd(16'h0069, 1'h0);
    wr(8'h1c, 32'h0000_0000);
    chk("bresp", 64'(dmz_pkg::RESP_SLVERR), 64'(rsp));
    rd(8'h1c);
    chk("rresp", 64'(dmz_pkg::RESP_SLVERR), 64'(rsp));
    summarize;
  end
endmodule
